// *** hw/lan_dma_status_and_mode_control.sv ***
/*
  Status and operating mode control for the descriptor DMA engines.
  Holds the process status register, the operating mode register and
  the transmit list base, and runs the transmit process sequencer.
  Assumes descriptor fetch, FIFO and MAC events arrive as one-cycle
  pulses on sys_clk, and that the receive engine reports its own state.
*/
// Implementation choices: the register offsets and strobed register access.
// Contract
// - Bus error field codes parity, master, target
// - Transmit state field at bits 22:20
// - Transmit stopped after reset or jabber
// - Running codes for fetch, wait, read, setup, close
// - Suspended on underflow or unavailable descriptor
// - Receive state bits 19:17, stopped after reset
// - Receive codes fetch, wait, close, queue
// - Receive codes check and suspended
// - Receive code for flushing frame
// - Event bits 0..16 cleared by writing one
// - Writes never change bits 17..25
// - Bit 31 enables enhanced capture resolution
// - Bit 17 enables capture-effect resolution
// - Threshold field selects transmit launch level
// - Run command starts transmit, checks list
// - Acquire from base or saved position
// - Unowned descriptor suspends, sets bit 2
// - Start honoured only when stopped
// - Clearing run stops after frame, saves position
// - Stop honoured only running or suspended
`timescale 1ns/1ps
module lan_dma_status_and_mode_control
  import lan_dma_pkg::*;
#(
  parameter int addr_w = 32
)(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [31:0]       reg_rdata,
  input  wire logic              desc_done,
  input  wire logic              desc_owned,
  input  wire logic              desc_is_setup,
  input  wire logic              buf_done,
  input  wire logic              frame_sent,
  input  wire logic              frame_irq_req,
  input  wire logic              close_done,
  input  wire logic              underflow,
  input  wire logic              jabber,
  input  wire logic              poll_demand,
  input  wire logic              bus_error,
  input  wire logic [2:0]        bus_error_kind,
  input  wire logic [2:0]        recv_state,
  input  wire logic [16:0]       other_events,
  output logic                   desc_fetch_req,
  output logic [addr_w-1:0]      desc_addr,
  output logic                   desc_advance,
  output logic [1:0]             fifo_launch_level,
  output logic                   collision_fairness_enable,
  output logic                   enhanced_fairness_enable
);

  // ==========================================================
  // Reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // Register decode
  logic wr_status;
  logic wr_mode;
  logic wr_base;

  assign wr_status = reg_write && (reg_addr == process_status_offset);
  assign wr_mode   = reg_write && (reg_addr == operating_mode_offset);
  assign wr_base   = reg_write && (reg_addr == xmit_list_base_offset);

  logic [31:0]       operating_mode;
  logic [addr_w-1:0] xmit_list_base;
  tx_state_t         tx_state;
  tx_state_t         next_tx_state;

  // ==========================================================
  // Operating mode register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      operating_mode <= operating_mode_reset;
    else if (wr_mode)
    begin
      operating_mode <= reg_wdata;
      // Threshold locked unless the transmitter is stopped
      if (tx_state != tx_stopped)
        operating_mode[launch_level_lsb +: 2] <= operating_mode[launch_level_lsb +: 2];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      xmit_list_base <= xmit_list_base_reset[addr_w-1:0];
    else if (wr_base)
      xmit_list_base <= reg_wdata[addr_w-1:0];
  end

  logic run_cmd;
  assign run_cmd = operating_mode[xmit_run_bit];

  // ==========================================================
  // Transmit sequencer
  logic stop_pending;
  logic run_prev;
  logic start_evt;
  logic stop_evt;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      run_prev <= 1'b0;
    else
      run_prev <= run_cmd;
  end

  assign start_evt = run_cmd && !run_prev && (tx_state == tx_stopped);
  assign stop_evt  = !run_cmd && run_prev && (tx_state != tx_stopped);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      stop_pending <= 1'b0;
    else if (tx_state == tx_stopped)
      stop_pending <= 1'b0;
    else if (stop_evt)
      stop_pending <= 1'b1;
  end

  always_comb
  begin
    next_tx_state = tx_state;
    case (tx_state)
      tx_stopped:
        if (start_evt)
          next_tx_state = tx_fetch;
      tx_fetch:
        if (stop_pending || stop_evt)
          next_tx_state = tx_stopped;
        else if (desc_done && !desc_owned)
          next_tx_state = tx_suspend;
        else if (desc_done && desc_is_setup)
          next_tx_state = tx_setup;
        else if (desc_done)
          next_tx_state = tx_read_buf;
      tx_read_buf:
        if (underflow)
          next_tx_state = tx_suspend;
        else if (buf_done)
          next_tx_state = tx_wait_end;
      tx_setup:
        if (buf_done)
          next_tx_state = tx_close;
      tx_wait_end:
        if (underflow)
          next_tx_state = tx_suspend;
        else if (frame_sent)
          next_tx_state = tx_close;
      tx_close:
        if (close_done)
          next_tx_state = (stop_pending || stop_evt) ? tx_stopped : tx_fetch;
      tx_suspend:
        // A stop left pending by an underflow must not strand the process here
        if (stop_pending || stop_evt)
          next_tx_state = tx_stopped;
        else if (poll_demand)
          next_tx_state = tx_fetch;
      default:
        next_tx_state = tx_stopped;
    endcase
    if (jabber)
      next_tx_state = tx_stopped;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_state <= tx_stopped;
    else
      tx_state <= next_tx_state;
  end

  // ==========================================================
  // Descriptor position: base on first start after reset or a base write, retained across stop
  logic base_loaded;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      base_loaded <= 1'b0;
    else if (wr_base)
      base_loaded <= 1'b0;
    else if (start_evt)
      base_loaded <= 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      desc_addr <= '0;
    else if (start_evt && !base_loaded)
      desc_addr <= xmit_list_base;
    else if (tx_state == tx_close && close_done)
      desc_addr <= desc_addr + addr_w'(16);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      desc_fetch_req <= 1'b0;
      desc_advance   <= 1'b0;
    end
    else
    begin
      desc_fetch_req <= (next_tx_state == tx_fetch) && (tx_state != tx_fetch);
      desc_advance   <= (tx_state == tx_close) && close_done;
    end
  end

  // ==========================================================
  // Status register
  logic [2:0]  xmit_code;
  logic [2:0]  bus_err_code;
  logic [16:0] events;
  logic [16:0] set_mask;
  logic [2:0]  recv_code;

  always_comb
  begin
    case (tx_state)
      tx_fetch:    xmit_code = xs_fetch;
      tx_read_buf: xmit_code = xs_read_buf;
      tx_setup:    xmit_code = xs_setup;
      tx_wait_end: xmit_code = xs_wait_end;
      tx_close:    xmit_code = xs_close;
      tx_suspend:  xmit_code = xs_suspend;
      default:     xmit_code = xs_stopped;
    endcase
  end

  // Receive codes pass through; reserved ones are impossible there
  assign recv_code = recv_state;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_err_code <= process_status_reset[bus_err_lsb +: 3];
    else if (bus_error && bus_error_kind <= bus_err_target)
      bus_err_code <= bus_error_kind;
  end

  always_comb
  begin
    set_mask = other_events;
    set_mask[xmit_done_bit]      = other_events[xmit_done_bit]
                                   | (tx_state == tx_close && close_done && frame_irq_req);
    set_mask[xmit_stopped_bit]   = (next_tx_state == tx_stopped) && (tx_state != tx_stopped);
    set_mask[xmit_unavail_bit]   = (tx_state == tx_fetch) && desc_done && !desc_owned;
    set_mask[xmit_jabber_bit]    = jabber;
    set_mask[xmit_underflow_bit] = underflow && (tx_state == tx_read_buf
                                                 || tx_state == tx_wait_end);
    set_mask[bus_err_flag_bit]   = other_events[bus_err_flag_bit] | bus_error;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      events <= process_status_reset[event_msb:0];
    else
    begin
      // Set beats clear in the same cycle
      events <= (events & ~(wr_status ? reg_wdata[event_msb:0] : 17'h0)) | set_mask;
    end
  end

  // ==========================================================
  // Read path and mode outputs
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (reg_read)
      case (reg_addr)
        process_status_offset:
          reg_rdata <= {process_status_reset[31:26], bus_err_code, xmit_code, recv_code, events};
        operating_mode_offset: reg_rdata <= operating_mode;
        xmit_list_base_offset: reg_rdata <= 32'(xmit_list_base);
        default:               reg_rdata <= 32'h0;
      endcase
    else
      reg_rdata <= 32'h0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fifo_launch_level         <= 2'h0;
      collision_fairness_enable <= 1'b0;
      enhanced_fairness_enable  <= 1'b0;
    end
    else
    begin
      fifo_launch_level         <= operating_mode[launch_level_lsb +: 2];
      collision_fairness_enable <= operating_mode[collision_fair_bit];
      enhanced_fairness_enable  <= operating_mode[enhanced_fair_bit];
    end
  end

endmodule

// *** hw/lan_dma_pkg.sv ***
/*
  Constants for the DMA status and operating mode block: register
  offsets, field positions, reset values and state encodings.
  Assumes a 32-bit register port addressed by byte offset.
*/
package lan_dma_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] process_status_offset = 8'h28;
  localparam logic [7:0] operating_mode_offset = 8'h30;
  localparam logic [7:0] xmit_list_base_offset = 8'h20;

  // ==========================================================
  // Reset values
  localparam logic [31:0] process_status_reset = 32'hfc000000;
  localparam logic [31:0] operating_mode_reset = 32'h00000000;
  localparam logic [31:0] xmit_list_base_reset = 32'h00000000;

  // ==========================================================
  // Field positions
  localparam int bus_err_lsb        = 23;
  localparam int xmit_state_lsb     = 20;
  localparam int recv_state_lsb     = 17;
  localparam int event_msb          = 16;
  localparam int enhanced_fair_bit  = 31;
  localparam int collision_fair_bit = 17;
  localparam int launch_level_lsb   = 14;
  localparam int xmit_run_bit       = 13;
  localparam int xmit_stopped_bit   = 1;
  localparam int xmit_unavail_bit   = 2;
  localparam int xmit_jabber_bit    = 3;
  localparam int xmit_underflow_bit = 5;
  localparam int xmit_done_bit      = 0;
  localparam int bus_err_flag_bit   = 13;

  // ==========================================================
  // Encodings
  localparam logic [2:0] bus_err_parity   = 3'h0;
  localparam logic [2:0] bus_err_master   = 3'h1;
  localparam logic [2:0] bus_err_target   = 3'h2;

  localparam logic [2:0] xs_stopped  = 3'h0;
  localparam logic [2:0] xs_fetch    = 3'h1;
  localparam logic [2:0] xs_wait_end = 3'h2;
  localparam logic [2:0] xs_read_buf = 3'h3;
  localparam logic [2:0] xs_setup    = 3'h5;
  localparam logic [2:0] xs_suspend  = 3'h6;
  localparam logic [2:0] xs_close    = 3'h7;

  localparam logic [2:0] rs_stopped  = 3'h0;
  localparam logic [2:0] rs_fetch    = 3'h1;
  localparam logic [2:0] rs_check    = 3'h2;
  localparam logic [2:0] rs_wait     = 3'h3;
  localparam logic [2:0] rs_suspend  = 3'h4;
  localparam logic [2:0] rs_close    = 3'h5;
  localparam logic [2:0] rs_flush    = 3'h6;
  localparam logic [2:0] rs_queue    = 3'h7;

  typedef enum {
    tx_stopped, tx_fetch, tx_read_buf, tx_setup, tx_wait_end, tx_close, tx_suspend
  } tx_state_t;

endpackage

// *** testbench/lan_dma_desc_model.sv ***
/* Descriptor memory stand-in: answers each fetch after lag cycles.
   Assumes at most one fetch outstanding. */
`timescale 1ns/1ps
module lan_dma_desc_model (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       desc_fetch_req,
  input  wire logic [7:0] lag,
  input  wire logic       own,
  input  wire logic       setup,
  output logic            desc_done,
  output logic            desc_owned,
  output logic            desc_is_setup
);
  logic [7:0] cnt;
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 8'h0;
      desc_done <= 1'b0;
      desc_owned <= 1'b0;
      desc_is_setup <= 1'b0;
    end
    else
    begin
      if (desc_fetch_req)
        cnt <= lag;
      else if (cnt != 8'h0)
        cnt <= cnt - 8'h1;
      desc_done <= (cnt == 8'h1);
      // Outside the answer cycle the levels toggle, never hold
      desc_owned <= (cnt == 8'h1) ? own : ~desc_owned;
      desc_is_setup <= (cnt == 8'h1) ? setup : ~desc_is_setup;
    end
  end
endmodule

// *** testbench/lan_dma_status_and_mode_control_monitor.sv ***
/* Port checker for the status and mode block.
   Assumes it is bound to the block's top module. */
`timescale 1ns/1ps
module lan_dma_status_and_mode_control_monitor
  import lan_dma_pkg::*;
#(
  parameter int addr_w = 32
)(
  input wire logic              sys_clk,
  input wire logic              rstn,
  input wire logic [7:0]        reg_addr,
  input wire logic              reg_read,
  input wire logic [31:0]       reg_rdata,
  input wire logic [2:0]        recv_state,
  input wire logic              desc_fetch_req,
  input wire logic [addr_w-1:0] desc_addr,
  input wire logic              desc_advance,
  input wire logic [1:0]        fifo_launch_level,
  input wire logic              collision_fairness_enable,
  input wire logic              enhanced_fairness_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic rs;
  logic rm;
  assign rs = reg_read && reg_addr == process_status_offset;
  assign rm = reg_read && reg_addr == operating_mode_offset;
  property p_err; rs |=> reg_rdata[25:23] <= 3'h2; endproperty
  a_err: assert property (p_err) else $error("bad bus error code");
  property p_tx; rs |=> reg_rdata[22:20] != 3'h4; endproperty
  a_tx: assert property (p_tx) else $error("reserved tx code");
  property p_top; rs |=> reg_rdata[31:26] == 6'h3f; endproperty
  a_top: assert property (p_top) else $error("status top bits");
  property p_rx; rs |=> reg_rdata[19:17] == $past(recv_state); endproperty
  a_rx: assert property (p_rx) else $error("rx state field");
  property p_lvl; rm |=> reg_rdata[15:14] == fifo_launch_level; endproperty
  a_lvl: assert property (p_lvl) else $error("launch level copy");
  property p_cfe; rm |=> reg_rdata[17] == collision_fairness_enable; endproperty
  a_cfe: assert property (p_cfe) else $error("fairness copy");
  property p_efe; rm |=> reg_rdata[31] == enhanced_fairness_enable; endproperty
  a_efe: assert property (p_efe) else $error("enhanced copy");
  property p_req; $rose(desc_fetch_req) |=> !desc_fetch_req; endproperty
  a_req: assert property (p_req) else $error("fetch not a pulse");
  property p_adr; desc_fetch_req |-> desc_addr[3:0] == 4'h0; endproperty
  a_adr: assert property (p_adr) else $error("descriptor misaligned");
  property p_adv; desc_advance |-> desc_addr == $past(desc_addr) + 'h10; endproperty
  a_adv: assert property (p_adv) else $error("descriptor step");
endmodule

bind lan_dma_status_and_mode_control lan_dma_status_and_mode_control_monitor
  #(.addr_w(addr_w)) mon_u (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .recv_state(recv_state),
  .desc_fetch_req(desc_fetch_req), .desc_addr(desc_addr), .desc_advance(desc_advance),
  .fifo_launch_level(fifo_launch_level),
  .collision_fairness_enable(collision_fairness_enable),
  .enhanced_fairness_enable(enhanced_fairness_enable));

// *** testbench/lan_dma_status_and_mode_control_tb.sv ***
/* Self-checking bench for the status and mode block.
   Assumes the descriptor model answers fetches; bench plays FIFO and MAC. */
`timescale 1ns/1ps
module lan_dma_status_and_mode_control_tb
  import lan_dma_pkg::*;
;
  localparam logic [7:0]  sa = process_status_offset;
  localparam logic [7:0]  ma = operating_mode_offset;
  localparam logic [31:0] tm = 32'h00700000;
  logic        sys_clk = 0, rstn = 0, reg_write = 0, reg_read = 0, own = 0, setup = 0;
  logic        past_rd = 0;
  logic [7:0]  reg_addr = 0, lag = 8'h0a;
  logic [31:0] reg_wdata = 0, rnd = 32'h8af9, r2, e, m, a;
  logic [6:0]  pl = 0;
  logic [2:0]  kind = 0, rx = 0;
  logic [16:0] oev = 0;
  wire logic [31:0] reg_rdata, desc_addr;
  wire logic        dd, dow, dst, desc_fetch_req;
  logic [31:0] eq[$], mq[$], aq[$];
  int          n_errors = 0, cmp_count = 0, cyc = 0;

  lan_dma_status_and_mode_control #(.addr_w(32)) dut_u (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .desc_done(dd), .desc_owned(dow), .desc_is_setup(dst),
    .buf_done(pl[0]), .frame_sent(pl[1]), .frame_irq_req(pl[2]), .close_done(pl[2]),
    .underflow(pl[3]), .jabber(pl[4]), .poll_demand(pl[5]), .bus_error(pl[6]),
    .bus_error_kind(kind), .recv_state(rx), .other_events(oev),
    .desc_fetch_req(desc_fetch_req), .desc_addr(desc_addr), .desc_advance(),
    .fifo_launch_level(), .collision_fairness_enable(), .enhanced_fairness_enable());
  lan_dma_desc_model mdl_u (.sys_clk(sys_clk), .rstn(rstn), .desc_fetch_req(desc_fetch_req),
    .lag(lag), .own(own), .setup(setup), .desc_done(dd), .desc_owned(dow),
    .desc_is_setup(dst));

  always #2 sys_clk = ~sys_clk;

  function logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function logic [31:0] tx(input logic [2:0] s);
    return {9'h0, s, 20'h0};
  endfunction
  task summarize;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic ok);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("Error %0t: mismatch", $time);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    reg_write <= 1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 0;
  endtask
  task rd(input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] mk);
    eq.push_back(ex);
    mq.push_back(mk);
    @(posedge sys_clk);
    reg_read <= 1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_read <= 0;
  endtask
  task go(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task pu(input int i);
    @(posedge sys_clk);
    pl[i] <= 1;
    @(posedge sys_clk);
    pl[i] <= 0;
    go(3);
  endtask
  // Bounded wait for the fetch pulse, checked after the edge settles
  task wf;
    int k;
    k = 0;
    #1;
    while (desc_fetch_req !== 1'b1 && k < 60)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk(k < 60);
  endtask

  // ==========================================================
  // Result watcher
  always @(posedge sys_clk)
  begin
    past_rd <= reg_read;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      summarize();
    end
  end
  always @(negedge sys_clk)
  begin
    if (past_rd)
    begin
      e = eq.pop_front();
      m = mq.pop_front();
      chk((reg_rdata & m) === (e & m));
    end
    if (desc_fetch_req === 1'b1)
    begin
      a = aq.pop_front();
      chk(a === '1 || desc_addr === a);
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    go(8);
    rstn <= 1;
    go(4);
    rd(sa, process_status_reset, '1);
    rd(ma, 32'h0, '1);
    rd(8'h04, 32'h0, '1);
    wr(xmit_list_base_offset, 32'h100);
    aq.push_back(32'h100);
    own <= 1;
    wr(ma, 32'h8002a000);
    wf();
    rd(sa, tx(xs_fetch), tm);
    go(12);
    rd(sa, tx(xs_read_buf), tm);
    pu(0);
    rd(sa, tx(xs_wait_end), tm);
    pu(1);
    rd(sa, tx(xs_close), tm);
    own <= 0;
    aq.push_back(32'h110);
    @(posedge sys_clk);
    pl[2] <= 1;
    @(posedge sys_clk);
    pl[2] <= 0;
    wf();
    go(12);
    rd(sa, tx(xs_suspend) | 32'h5, tm | 32'h7);
    wr(sa, 32'h03fe0001);
    rd(sa, tx(xs_suspend) | 32'h4, tm | 32'h7);
    wr(ma, 32'h80026000);
    rd(ma, 32'h8002a000, '1);
    wr(ma, 32'h80020000);
    rd(sa, tx(xs_stopped) | 32'h2, tm | 32'h2);
    aq.push_back(32'h110);
    own <= 1;
    setup <= 1;
    wr(ma, 32'h80026000);
    wf();
    rd(ma, 32'h80026000, '1);
    go(12);
    rd(sa, tx(xs_setup), tm);
    pu(4);
    rd(sa, tx(xs_stopped) | 32'h8, tm | 32'h8);
    setup <= 0;
    aq.push_back(32'h110);
    // Start is an edge of the run bit: clear it after the jabber stop first
    wr(ma, 32'h0);
    wr(ma, 32'h00002000);
    wf();
    go(12);
    rd(sa, tx(xs_read_buf), tm);
    pu(3);
    rd(sa, tx(xs_suspend) | 32'h20, tm | 32'h20);
    wr(ma, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      kind <= i[2:0];
      pu(6);
      rd(sa, {6'h0, (i < 3) ? i[2:0] : 3'h2, 23'h2000}, 32'h03802000);
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(sa, '1);
      rnd = xs(rnd);
      @(posedge sys_clk);
      rx <= i[2:0];
      oev <= rnd[16:0];
      @(posedge sys_clk);
      oev <= 0;
      rd(sa, {12'h0, i[2:0], rnd[16:0]}, 32'h000fffd1);
    end
    r2 = xs(rnd);
    wr(sa, {15'h0, r2[16:0]});
    rd(sa, {15'h0, rnd[16:0] & ~r2[16:0]}, 32'h0001ffd1);
    go(4);
    summarize();
  end
endmodule
